// file: nvmc_ctrl.sv
`timescale 1ns/10ps
`include "nvmc_cfg.svh"
module nvmc_ctrl #(
    parameter int unsigned ADDR_W = 13,
    parameter int unsigned EE_OP_CYC =
        `NVMC_EE_OP_TIME_NS / `NVMC_CLK_PERIOD_NS,
    parameter int unsigned FL_OP_CYC =
        `NVMC_FL_OP_TIME_NS / `NVMC_CLK_PERIOD_NS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic warm_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire nvmc_pkg::nvmc_tbl_t tbl,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    output logic [23:0] arr_raddr,
    input wire logic [15:0] arr_rdata,
    output nvmc_pkg::nvmc_cmd_t arr_cmd,
    output nvmc_pkg::nvmc_beat_t arr_beat,
    input wire logic done_clr,
    output logic nvm_done_flag,
    output logic cpu_stall
);
    import nvmc_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] nw, input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction
    function automatic logic in_ee(input logic [23:0] a);
        in_ee = a >= `NVMC_EE_BASE && a <= `NVMC_EE_LAST;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic wr;
    logic write_allow_bit;
    logic write_abort_flag;
    logic write_interval_bit;
    logic [`NVMC_OPSEL_HI:0] operation_select;
    logic [15:0] nvm_addr_low;
    logic [7:0] nvm_addr_upper;
    logic [23:0] latch [`NVMC_ROW_WORDS];
    nvmc_op_t op_state;
    nvmc_cmd_t op;
    logic [5:0] beat_cnt;
    logic [5:0] beat_total;
    logic [4:0] beat_base;
    logic rd_pend;
    logic op_done;
    logic key_armed;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire hit_ctrl = avs_address == byte_addr(`NVMC_IDX_CONTROL);
    wire hit_low = avs_address == byte_addr(`NVMC_IDX_ADDR_LOW);
    wire hit_up = avs_address == byte_addr(`NVMC_IDX_ADDR_UPPER);
    wire hit_key = avs_address == byte_addr(`NVMC_IDX_KEY);
    wire wr_take = avs_write && !avs_waitrequest;
    wire rd_first = avs_read && avs_waitrequest;
    wire [15:0] wdata16 = avs_writedata[15:0];
    wire [1:0] be = avs_byteenable[1:0];
    wire busy = op_state == OP_BUSY;

    // control register as read, unimplemented bits zero
    wire [15:0] ctrl_view = {wr, write_allow_bit, write_abort_flag, 4'h0,
        write_interval_bit, 1'b0, operation_select};
    wire [15:0] ctrl_new = merge16(ctrl_view, wdata16, be);
    wire ctrl_take = wr_take && hit_ctrl;

    // start needs the unlocked key and a previously set write-allow
    wire start_ok = ctrl_take && ctrl_new[`NVMC_BIT_WR] && key_armed
        && write_allow_bit && !busy && !warm_rst;
    wire [15:0] read_mux = hit_ctrl ? ctrl_view
        : hit_low ? nvm_addr_low
        : hit_up ? {8'h00, nvm_addr_upper}
        : 16'h0000; // key and unmapped read zero
    wire [23:0] tgt_addr = {nvm_addr_upper, nvm_addr_low};
    wire op_ee = operation_select[`NVMC_OP_EE_BIT];
    wire op_multi = operation_select[`NVMC_OP_BLK_BIT];
    wire [4:0] addr_idx = nvm_addr_low[5:1];
    wire [4:0] tbl_idx = tbl.addr[5:1];
    wire tbl_wr = tbl.valid && tbl.write;
    wire tbl_rd_ee = tbl.valid && !tbl.write && in_ee(tbl.addr);
    // latch slot of the current beat
    wire [4:0] beat_idx = beat_base + beat_cnt[4:0];

    // ****************************************************************
    // sub blocks
    // ****************************************************************
    nvmc_key_guard u_key (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_take(wr_take),
        .key_hit(hit_key && be[0]),
        .key_data(wdata16[7:0]),
        .brk(warm_rst || tbl.valid),
        .armed(key_armed)
    );
    nvmc_op_timer #(
        .EE_CYC(EE_OP_CYC),
        .FL_CYC(FL_OP_CYC)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(start_ok),
        .flash(!op_ee),
        .abort(warm_rst),
        .done(op_done)
    );

    // ****************************************************************
    // avalon slave, one wait cycle per access
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (rd_first)
                avs_readdata <= {16'h0000, read_mux};
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr <= 1'(`NVMC_CONTROL_RESET >> `NVMC_BIT_WR);
            write_allow_bit <= 1'b0;
            write_abort_flag <= 1'b0;
            write_interval_bit <= 1'b0;
            operation_select <= '0;
        end
        else if (warm_rst)
        begin
            wr <= 1'b0;
            write_allow_bit <= 1'b0;
            write_abort_flag <= busy || write_abort_flag;
            write_interval_bit <= 1'b0;
            operation_select <= '0;
        end
        else
        begin
            // software can set start, only hardware clears it
            if (op_done)
                wr <= 1'b0;
            else if (start_ok)
                wr <= 1'b1;
            if (ctrl_take)
            begin
                write_allow_bit <= ctrl_new[`NVMC_BIT_WRITE_ALLOW_BIT];
                write_abort_flag <= ctrl_new[`NVMC_BIT_WRITE_ABORT_FLAG];
                write_interval_bit <= ctrl_new[`NVMC_BIT_WRITE_INTERVAL_BIT];
                operation_select <= ctrl_new[`NVMC_OPSEL_HI:0];
            end
        end
    end

    // ****************************************************************
    // address registers, survive warm reset
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_addr_low <= 16'h0000;
            nvm_addr_upper <= 8'h00;
        end
        else if (tbl.valid)
        begin
            nvm_addr_low <= tbl.addr[15:0];
            nvm_addr_upper <= tbl.addr[23:16];
        end
        else if (wr_take)
        begin
            if (hit_low)
                nvm_addr_low <= merge16(nvm_addr_low, wdata16, be);
            if (hit_up && be[0])
                nvm_addr_upper <= wdata16[7:0];
        end
    end

    // ****************************************************************
    // write latches loaded by table writes
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (tbl_wr && tbl.high)
            latch[tbl_idx][23:16] <= tbl.wdata[7:0];
        else if (tbl_wr)
            latch[tbl_idx][15:0] <= tbl.wdata;
    end

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_state <= OP_IDLE;
            op <= '0;
            arr_cmd <= '0;
            beat_cnt <= 6'h00;
            beat_total <= 6'h00;
            beat_base <= 5'h00;
            cpu_stall <= 1'b0;
        end
        else
        begin
            arr_cmd.go <= 1'b0;
            unique case (op_state)
                OP_IDLE:
                    if (start_ok)
                    begin
                        op_state <= OP_BUSY;
                        op <= {1'b1, operation_select[`NVMC_OP_ERASE_BIT],
                            op_ee, op_multi, tgt_addr};
                        arr_cmd <= {1'b1, operation_select[`NVMC_OP_ERASE_BIT],
                            op_ee, op_multi, tgt_addr};
                        // word count of the operation
                        beat_total <= !op_ee ? `NVMC_ROW_WORDS
                            : op_multi ? `NVMC_EE_BLOCK_WORDS
                            : 6'h01;
                        beat_base <= !op_ee ? 5'h00
                            : op_multi ? {addr_idx[4], 4'h0} : addr_idx;
                        beat_cnt <= 6'h00;
                        cpu_stall <= !op_ee;
                    end
                OP_BUSY:
                    if (warm_rst || op_done)
                    begin
                        op_state <= OP_IDLE;
                        cpu_stall <= 1'b0;
                    end
                    else if (beat_cnt != beat_total)
                        beat_cnt <= beat_cnt + 6'h01;
            endcase
        end
    end

    // stream latch words to the array while programming
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            arr_beat <= '0;
        else
        begin
            arr_beat.valid <= busy && !op.erase && beat_cnt != beat_total;
            arr_beat.idx <= beat_idx;
            arr_beat.data <= latch[beat_idx];
        end
    end

    // ****************************************************************
    // done flag, a new completion wins over a clear
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            nvm_done_flag <= 1'b0;
        else if (op_done)
            nvm_done_flag <= 1'b1;
        else if (done_clr)
            nvm_done_flag <= 1'b0;
    end

    // ****************************************************************
    // eeprom table reads, undefined while an eeprom op runs
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arr_raddr <= 24'h000000;
            rd_pend <= 1'b0;
            tbl_rvalid <= 1'b0;
            tbl_rdata <= 16'h0000;
        end
        else
        begin
            rd_pend <= tbl_rd_ee;
            if (tbl_rd_ee)
                arr_raddr <= tbl.addr;
            tbl_rvalid <= rd_pend;
            if (rd_pend)
                tbl_rdata <= (busy && op.eeprom) ? `NVMC_UNDEF_DATA
                    : arr_rdata;
        end
    end
endmodule // nvmc_ctrl

// file: nvmc_cfg.svh
`ifndef NVMC_CFG_SVH
`define NVMC_CFG_SVH
// ****************************************************************
// register indexes, byte address is four times the index
// ****************************************************************
`define NVMC_IDX_CONTROL 12'h760
`define NVMC_IDX_ADDR_LOW 12'h762
`define NVMC_IDX_ADDR_UPPER 12'h764
`define NVMC_IDX_KEY 12'h766
`define NVMC_CONTROL_RESET 16'h0000
`define NVMC_KEY_RESET 16'h0000
// ****************************************************************
// control field positions
// ****************************************************************
`define NVMC_BIT_WR 15
`define NVMC_BIT_WRITE_ALLOW_BIT 14
`define NVMC_BIT_WRITE_ABORT_FLAG 13
`define NVMC_BIT_WRITE_INTERVAL_BIT 8
`define NVMC_OPSEL_HI 6
`define NVMC_OP_ERASE_BIT 6
`define NVMC_OP_EE_BIT 2
`define NVMC_OP_BLK_BIT 0
// ****************************************************************
// keys, memory map and sizes
// ****************************************************************
`define NVMC_KEY_FIRST 8'h55
`define NVMC_KEY_SECOND 8'hAA
`define NVMC_EE_BASE 24'h7FF000
`define NVMC_EE_LAST 24'h7FFFFE
`define NVMC_EE_BLOCK_WORDS 6'h10
`define NVMC_ROW_WORDS 6'h20
`define NVMC_UNDEF_DATA 16'hFFFF
// ****************************************************************
// timing
// ****************************************************************
`define NVMC_CLK_PERIOD_NS 100
`define NVMC_EE_OP_TIME_NS 2000000
`define NVMC_FL_OP_TIME_NS 2000000
`endif

// file: nvmc_pkg.sv
package nvmc_pkg;
    // table instruction seen by the block
    typedef struct packed {
        logic valid;
        logic write;
        logic high;
        logic [23:0] addr;
        logic [15:0] wdata;
    } nvmc_tbl_t;
    // command to the array
    typedef struct packed {
        logic go;
        logic erase;
        logic eeprom;
        logic multi;
        logic [23:0] addr;
    } nvmc_cmd_t;
    // one latch word streamed to the array
    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [23:0] data;
    } nvmc_beat_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} nvmc_key_t;
    typedef enum logic {OP_IDLE, OP_BUSY} nvmc_op_t;
endpackage

// file: nvmc_op_timer.sv
`timescale 1ns/10ps
`include "nvmc_cfg.svh"
module nvmc_op_timer #(
    parameter int unsigned EE_CYC = 20000,
    parameter int unsigned FL_CYC = 20000,
    parameter int unsigned CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic flash,
    input wire logic abort,
    output logic done
);
    import nvmc_pkg::*;
    logic [CNT_W-1:0] cnt;
    logic running;
    // ****************************************************************
    // operation duration count
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= running && !abort && cnt == CNT_W'(1);
            if (abort || (running && cnt == CNT_W'(1)))
                running <= 1'b0;
            else if (start)
            begin
                running <= 1'b1;
                cnt <= flash ? CNT_W'(FL_CYC) : CNT_W'(EE_CYC);
            end
            else if (running)
                cnt <= cnt - CNT_W'(1);
        end
    end
endmodule // nvmc_op_timer

// file: nvmc_key_guard.sv
`timescale 1ns/10ps
`include "nvmc_cfg.svh"
module nvmc_key_guard (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_take,
    input wire logic key_hit,
    input wire logic [7:0] key_data,
    input wire logic brk,
    output logic armed
);
    import nvmc_pkg::*;
    nvmc_key_t state;
    nvmc_key_t next_state;
    // ****************************************************************
    // unlock sequence, any other bus write or table instruction in between drops it; bus reads do not
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        if (brk)
            next_state = KEY_IDLE;
        else if (wr_take)
        begin
            unique case (state)
                KEY_IDLE, KEY_ARMED:
                    next_state = (key_hit && key_data == `NVMC_KEY_FIRST)
                        ? KEY_GOT_FIRST : KEY_IDLE;
                KEY_GOT_FIRST:
                    next_state = (key_hit && key_data == `NVMC_KEY_SECOND)
                        ? KEY_ARMED : KEY_IDLE;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= KEY_IDLE;
        else
            state <= next_state;
    end
    assign armed = state == KEY_ARMED;
endmodule // nvmc_key_guard

// file: nvmc_ctrl_properties.sv
`timescale 1ns/10ps
`include "nvmc_cfg.svh"
module nvmc_ctrl_chk #(
    parameter int unsigned ADDR_W = 13,
    parameter int unsigned EE_OP_CYC = 40,
    parameter int unsigned FL_OP_CYC = 40
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic warm_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire nvmc_pkg::nvmc_tbl_t tbl,
    input wire logic [15:0] tbl_rdata,
    input wire logic tbl_rvalid,
    input wire logic [23:0] arr_raddr,
    input wire logic [15:0] arr_rdata,
    input wire nvmc_pkg::nvmc_cmd_t arr_cmd,
    input wire nvmc_pkg::nvmc_beat_t arr_beat,
    input wire logic done_clr,
    input wire logic nvm_done_flag,
    input wire logic cpu_stall
);
    import nvmc_pkg::*;
    localparam int LIM = ((EE_OP_CYC > FL_OP_CYC) ? EE_OP_CYC : FL_OP_CYC) + 4;
    localparam logic [12:0] A_CTL = 13'(`NVMC_IDX_CONTROL * 4);
    localparam logic [12:0] A_KEY = 13'(`NVMC_IDX_KEY * 4);
    logic [1:0] armed;
    logic allow_q;
    logic ok_q;
    // accepted writes and a legal start request
    wire acc_w = avs_write && !avs_waitrequest;
    wire [15:0] wd = avs_writedata[15:0];
    wire key_w = acc_w && avs_address == A_KEY;
    wire ctl_w = acc_w && avs_address == A_CTL;
    wire start_ok = ctl_w && wd[15] && allow_q && armed == 2'h2;
    // shadow of the unlock sequence and the prior write-allow
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed <= 2'h0;
            allow_q <= 1'h0;
            ok_q <= 1'h0;
        end
        else
        begin
            ok_q <= start_ok;
            allow_q <= warm_rst ? 1'h0 : (ctl_w ? wd[14] : allow_q);
            if (warm_rst || tbl.valid)
                armed <= 2'h0;
            else if (key_w && wd[7:0] == `NVMC_KEY_FIRST)
                armed <= 2'h1;
            else if (key_w && armed == 2'h1 && wd[7:0] == `NVMC_KEY_SECOND)
                armed <= 2'h2;
            else if (acc_w)
                armed <= 2'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n || warm_rst);
    sequence prog_beats;
        arr_beat.valid [*8];
    endsequence
    sequence one_beat;
        arr_beat.valid ##1 !arr_beat.valid;
    endsequence
    chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    chk_go_needs_key: assert property (
        $rose(arr_cmd.go) |-> ok_q || $past(ok_q))
        else $error("operation began without unlock");
    chk_ee_no_stall: assert property (
        arr_cmd.go && arr_cmd.eeprom |-> !cpu_stall [*8])
        else $error("eeprom operation stalled the core");
    chk_fl_stall: assert property (
        arr_cmd.go && !arr_cmd.eeprom |-> ##[0:1] cpu_stall)
        else $error("flash operation did not stall");
    chk_row_beats: assert property (
        arr_cmd.go && !arr_cmd.eeprom && !arr_cmd.erase |=> prog_beats)
        else $error("flash row not streamed");
    chk_word_beat: assert property (
        arr_cmd.go && arr_cmd.eeprom && !arr_cmd.erase && !arr_cmd.multi
        |=> one_beat) else $error("word program not one beat");
    chk_done_bound: assert property (
        arr_cmd.go |-> ##[1:LIM] (nvm_done_flag && !cpu_stall))
        else $error("operation never completed");
    chk_done_sticky: assert property (
        nvm_done_flag && !done_clr |=> nvm_done_flag)
        else $error("done flag dropped by itself");
    chk_ctl_unimpl: assert property (
        avs_read && !avs_waitrequest && avs_address == A_CTL
        |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[12:9] == 4'h0
        && !avs_readdata[7]) else $error("control unused bits set");
    chk_key_reads0: assert property (
        avs_read && !avs_waitrequest && avs_address == A_KEY
        |-> avs_readdata == 32'h00000000) else $error("key readable");
endmodule // nvmc_ctrl_chk
bind nvmc_ctrl nvmc_ctrl_chk #(.ADDR_W(ADDR_W), .EE_OP_CYC(EE_OP_CYC),
    .FL_OP_CYC(FL_OP_CYC)) nvmc_ctrl_chk_i (.core_clk(core_clk),
    .rst_n(rst_n), .warm_rst(warm_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tbl(tbl), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
    .arr_raddr(arr_raddr), .arr_rdata(arr_rdata), .arr_cmd(arr_cmd),
    .arr_beat(arr_beat), .done_clr(done_clr),
    .nvm_done_flag(nvm_done_flag), .cpu_stall(cpu_stall));

// file: nvmc_array_model.sv
`timescale 1ns/10ps
module nvmc_array_model (
    input wire logic core_clk,
    input wire logic [23:0] arr_raddr,
    input wire nvmc_pkg::nvmc_cmd_t arr_cmd,
    input wire nvmc_pkg::nvmc_beat_t arr_beat,
    output logic [15:0] arr_rdata
);
    import nvmc_pkg::*;
    logic [15:0] mem [0:2047];
    // word array addressed by the eeprom offset
    assign arr_rdata = mem[arr_raddr[11:1]];
    initial
    begin
        for (int i = 0; i < 2048; i++)
            mem[i] = 16'h0000;
    end
    // erase to all ones, program from the streamed latch words
    always @(posedge core_clk)
    begin
        if (arr_cmd.go && arr_cmd.eeprom && arr_cmd.erase && arr_cmd.multi)
            for (int i = 0; i < 16; i++)
                mem[{arr_cmd.addr[11:5], 4'(i)}] <= 16'hFFFF;
        else if (arr_cmd.go && arr_cmd.eeprom && arr_cmd.erase)
            mem[arr_cmd.addr[11:1]] <= 16'hFFFF;
        if (arr_beat.valid && arr_cmd.eeprom && !arr_cmd.erase)
            mem[{arr_cmd.addr[11:6], arr_beat.idx}] <=
                arr_beat.data[15:0];
    end
endmodule // nvmc_array_model

// file: nvmc_ctrl_tb.sv
`timescale 1ns/10ps
`include "nvmc_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t got %h want %h", $time, g, e); end end
module nvmc_ctrl_tb;
    import nvmc_pkg::*;
    // ****************************************************************
    // stimulus and checking of the unlock and operation sequencer
    // ****************************************************************
    localparam int unsigned OPC = 40;
    localparam logic [12:0] A_CTL = 13'(`NVMC_IDX_CONTROL * 4);
    localparam logic [12:0] A_LOW = 13'(`NVMC_IDX_ADDR_LOW * 4);
    localparam logic [12:0] A_UP = 13'(`NVMC_IDX_ADDR_UPPER * 4);
    localparam logic [12:0] A_KEY = 13'(`NVMC_IDX_KEY * 4);
    logic core_clk = 1'h0, rst_n = 1'h0, warm_rst = 1'h0, done_clr = 1'h0;
    logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, tbl_rvalid;
    logic [12:0] avs_address = 13'h0000;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic [3:0] avs_byteenable = 4'h3;
    logic nvm_done_flag, cpu_stall;
    logic [15:0] tbl_rdata, arr_rdata, rd;
    logic [23:0] arr_raddr;
    nvmc_tbl_t tbl = '0;
    nvmc_cmd_t arr_cmd;
    nvmc_beat_t arr_beat;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    nvmc_ctrl #(.EE_OP_CYC(OPC), .FL_OP_CYC(OPC)) nvmc_ctrl_i (
        .core_clk(core_clk), .rst_n(rst_n), .warm_rst(warm_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tbl(tbl), .tbl_rdata(tbl_rdata),
        .tbl_rvalid(tbl_rvalid), .arr_raddr(arr_raddr),
        .arr_rdata(arr_rdata), .arr_cmd(arr_cmd), .arr_beat(arr_beat),
        .done_clr(done_clr), .nvm_done_flag(nvm_done_flag),
        .cpu_stall(cpu_stall));
    nvmc_array_model nvmc_array_model_i (.core_clk(core_clk),
        .arr_raddr(arr_raddr), .arr_cmd(arr_cmd), .arr_beat(arr_beat),
        .arr_rdata(arr_rdata));
    // clock and hang guard
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            finish_test;
        end
    end
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one bus cycle, held until the wait cycle ends
    task bus(input logic w, input logic [12:0] a, input logic [15:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata[15:0];
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task rdchk(input logic [12:0] a, input logic [15:0] e);
        bus(1'h0, a, 16'h0000);
        `CHK(rd, e)
    endtask
    // one table instruction; a read returns its word in rd
    task tblop(input logic w, input logic [23:0] a, input logic [15:0] d);
        @(posedge core_clk);
        tbl <= '{1'h1, w, 1'h0, a, d};
        @(posedge core_clk);
        tbl <= '0;
        rd = 16'h1357;
        repeat (4)
        begin
            @(posedge core_clk);
            if (tbl_rvalid === 1'h1)
                rd = tbl_rdata;
        end
    endtask
    task unlock(input logic [15:0] c);
        bus(1'h1, A_KEY, {8'h00, `NVMC_KEY_FIRST});
        bus(1'h1, A_KEY, {8'h00, `NVMC_KEY_SECOND});
        bus(1'h1, A_CTL, c);
    endtask
    task op(input logic [15:0] c);
        bus(1'h1, A_CTL, c & 16'h7FFF);
        unlock(c);
        repeat (2) @(posedge core_clk);
    endtask
    task wait_done;
        for (int i = 0; i < 3 * OPC && nvm_done_flag !== 1'h1; i++)
            @(posedge core_clk);
        `CHK(nvm_done_flag, 1'h1)
        done_clr <= 1'h1;
        @(posedge core_clk);
        done_clr <= 1'h0;
    endtask
    task t_reset;
        rdchk(A_CTL, 16'h0000);
        bus(1'h1, A_KEY, 16'h0055);
        rdchk(A_KEY, 16'h0000);
        rdchk(13'h0004, 16'h0000);
        bus(1'h1, A_UP, 16'hFFFF);
        rdchk(A_UP, 16'h00FF);
    endtask
    task t_refuse;
        bus(1'h1, A_CTL, 16'h4044);
        bus(1'h1, A_CTL, 16'hC044);
        rdchk(A_CTL, 16'h4044);
        bus(1'h1, A_KEY, 16'h00AA);
        bus(1'h1, A_KEY, 16'h0055);
        bus(1'h1, A_CTL, 16'hC044);
        rdchk(A_CTL, 16'h4044);
        bus(1'h1, A_CTL, 16'h0044);
        unlock(16'hC044);
        rdchk(A_CTL, 16'h4044);
    endtask
    task t_word;
        tblop(1'h1, 24'h7FF012, 16'hBEEF);
        rdchk(A_LOW, 16'hF012);
        rdchk(A_UP, 16'h007F);
        op(16'hC044);
        wait_done;
        op(16'hC004);
        rdchk(A_CTL, 16'hC004);
        bus(1'h1, A_CTL, 16'h0004);
        rdchk(A_CTL, 16'h8004);
        `CHK(cpu_stall, 1'h0)
        tblop(1'h0, 24'h7FF012, 16'h0000);
        `CHK(rd, `NVMC_UNDEF_DATA)
        wait_done;
        rdchk(A_CTL, 16'h0004);
        tblop(1'h0, 24'h7FF012, 16'h0000);
        `CHK(rd, 16'hBEEF)
        op(16'hC044);
        wait_done;
        tblop(1'h0, 24'h7FF012, 16'h0000);
        `CHK(rd, 16'hFFFF)
    endtask
    task t_block;
        tblop(1'h0, 24'h7FF014, 16'h0000);
        op(16'hC045);
        wait_done;
        tblop(1'h0, 24'h7FF01E, 16'h0000);
        `CHK(rd, 16'hFFFF)
        tblop(1'h0, 24'h7FF024, 16'h0000);
        `CHK(rd, 16'h0000)
    endtask
    task t_flash;
        op(16'hC041);
        wait_done;
        op(16'hC001);
        repeat (3) @(posedge core_clk);
        `CHK(cpu_stall, 1'h1)
        wait_done;
        `CHK(cpu_stall, 1'h0)
    endtask
    task t_abort;
        tblop(1'h1, 24'h7FF030, 16'h1111);
        op(16'hC004);
        repeat (5) @(posedge core_clk);
        warm_rst <= 1'h1;
        @(posedge core_clk);
        warm_rst <= 1'h0;
        rdchk(A_CTL, 16'h2000);
        rdchk(A_LOW, 16'hF030);
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        t_reset;
        t_refuse;
        t_word;
        t_block;
        t_flash;
        t_abort;
        finish_test;
    end
endmodule // nvmc_ctrl_tb
